// [bench/multichip_counter_sync_tb.sv]
/*
  Self-checking bench for multichip_counter_sync.
  Needs sync_pkg, the bound checker and sync_partner.
*/
`timescale 1ns/1ps
module multichip_counter_sync_tb;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
  logic [31:0] wData = 32'h0000_0000, rData;
  logic [1:0] bResp, rResp, mode = 2'h0;
  logic awValid = 1'h0, wValid = 1'h0, bReady = 1'h0;
  logic arValid = 1'h0, rReady = 1'h0, slaveReq = 1'h0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic slvReq, loadPulse, stalled, irq;
  logic [63:0] counterIn = 64'h0000_0000_0000_0000, loadValue;
  sync_pkg::sync_msg_s mstMsg, resp;
  int err_total = 0, check_count = 0, cyc = 0, loadN = 0;
  int reqN = 0, reqLast = 0, reqGap = 999, mstN = 0, mstLast = 0;
  int mstGap = 999;
  localparam logic [1:0] OK = sync_pkg::RESP_OKAY;

  multichip_counter_sync #(.TIMEOUT_CYCLES(8)) dut (.clock(clock),
    .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .counterIn(counterIn),
    .slaveReqIn(slaveReq), .mstTxMsg(mstMsg), .slvReqOut(slvReq),
    .slvRespMsg(resp), .loadPulse(loadPulse), .loadValue(loadValue),
    .stalled(stalled), .irq(irq));
  sync_partner far (.clock(clock), .rst(rst), .req(slvReq),
    .mode(mode), .resp(resp));

  initial
  begin
    forever #25 clock = ~clock;
  end

  task automatic tally_and_finish();
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Monitors: counts and minimum spacing of starts
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    counterIn <= counterIn + 64'h1;
    if (cyc > 20000)
    begin
      err_total = err_total + 1;
      tally_and_finish();
    end
    if (loadPulse)
      loadN <= loadN + 1;
    if (slvReq)
    begin
      if (reqN > 0 && cyc - reqLast < reqGap)
        reqGap <= cyc - reqLast;
      reqN <= reqN + 1;
      reqLast <= cyc;
    end
    if (mstMsg.valid)
    begin
      if (mstN > 0 && cyc - mstLast < mstGap)
        mstGap <= cyc - mstLast;
      mstN <= mstN + 1;
      mstLast <= cyc;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    awAddr <= a;
    wData <= d;
    awValid <= 1'h1;
    wValid <= 1'h1;
    while (!(aw && w))
    begin
      @(posedge clock);
      if (awValid && awReady)
      begin
        aw = 1'h1;
        awValid <= 1'h0;
      end
      if (wValid && wReady)
      begin
        w = 1'h1;
        wValid <= 1'h0;
      end
    end
    bReady <= 1'h1;
    do @(posedge clock); while (!bValid);
    bReady <= 1'h0;
    check(64'(bResp), 64'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    arAddr <= a;
    arValid <= 1'h1;
    do @(posedge clock); while (!arReady);
    arValid <= 1'h0;
    rReady <= 1'h1;
    do @(posedge clock); while (!rValid);
    rReady <= 1'h0;
    check(64'(rData), 64'(ed));
    check(64'(rResp), 64'(er));
  endtask

  task automatic waitN(ref int n, input int goal);
    for (int i = 0; i < 300 && n < goal; i++) @(posedge clock);
    repeat (3) @(posedge clock);
  endtask

  task automatic tReset();
    logic [7:0] offs [6];
    offs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h28};
    foreach (offs[i]) rd(offs[i], 32'h0000_0000, OK);
    rd(8'h14, 32'h0000_0000, sync_pkg::RESP_SLVERR);
    wr(8'h14, 32'h0000_0001, sync_pkg::RESP_SLVERR);
  endtask

  task automatic tMaster();
    slaveReq <= 1'h1;
    @(posedge clock);
    slaveReq <= 1'h0;
    repeat (6) @(posedge clock);
    check(64'(mstN), 64'h0);
    wr(sync_pkg::OFF_MST_CTRL, 32'h0000_0019, OK);
    // Second request lands while the first start still blocks
    slaveReq <= 1'h1;
    @(posedge clock);
    slaveReq <= 1'h0;
    @(posedge clock);
    slaveReq <= 1'h1;
    @(posedge clock);
    slaveReq <= 1'h0;
    waitN(mstN, 2);
    check(64'(mstGap), 64'h6);
    wr(sync_pkg::OFF_MST_CTRL, 32'h0000_001B, OK);
    waitN(mstN, 3);
    check(64'(mstN), 64'h3);
    wr(sync_pkg::OFF_MST_CTRL, 32'h0000_0000, OK);
  endtask

  task automatic tPass();
    wr(sync_pkg::OFF_IRQ_MASK, 32'h0000_0002, OK);
    wr(sync_pkg::OFF_SLV_CTRL, 32'h0000_0001, OK);
    waitN(loadN, 1);
    check(loadValue, far.BASE);
    rd(sync_pkg::OFF_IRQ_STATUS, 32'h0000_0000, OK);
    wr(sync_pkg::OFF_SLV_CTRL, 32'h0000_0003, OK);
    waitN(loadN, 2);
    check(loadValue, far.BASE + 64'h1);
    rd(sync_pkg::OFF_IRQ_STATUS, 32'h0000_0002, OK);
    check(64'(irq), 64'h1);
    wr(sync_pkg::OFF_IRQ_STATUS, 32'h0000_0002, OK);
    check(64'(irq), 64'h0);
    wr(sync_pkg::OFF_SLV_CTRL, 32'h0000_0000, OK);
  endtask

  task automatic tFail();
    wr(sync_pkg::OFF_RETRY_LIMIT, 32'h0000_0002, OK);
    wr(sync_pkg::OFF_SLV_CTRL, 32'h0000_0025, OK);
    waitN(loadN, 3);
    reqN = 0;
    reqGap = 999;
    mode <= 2'h1;
    wr(sync_pkg::OFF_SLV_CTRL, 32'h0000_0027, OK);
    for (int i = 0; i < 300 && !stalled; i++) @(posedge clock);
    repeat (3) @(posedge clock);
    check(64'(reqN), 64'h3);
    check(64'(reqGap >= 9), 64'h1);
    check(64'(stalled), 64'h1);
    rd(sync_pkg::OFF_SYNC_STATE, 32'h0000_0001, OK);
    rd(sync_pkg::OFF_IRQ_STATUS, 32'h0000_0005, OK);
    wr(sync_pkg::OFF_IRQ_MASK, 32'h0000_000F, OK);
    check(64'(irq), 64'h1);
    wr(sync_pkg::OFF_IRQ_STATUS, 32'h0000_000F, OK);
    wr(sync_pkg::OFF_SLV_CTRL, 32'h0000_0000, OK);
    // Engine leaves the stall one clock after the enable lands
    @(posedge clock);
    check(64'(stalled), 64'h0);
  endtask

  task automatic tTimeout();
    mode <= 2'h2;
    wr(sync_pkg::OFF_RETRY_LIMIT, 32'h0000_0000, OK);
    reqN = 0;
    wr(sync_pkg::OFF_SLV_CTRL, 32'h0000_0001, OK);
    for (int i = 0; i < 300 && !stalled; i++) @(posedge clock);
    repeat (3) @(posedge clock);
    check(64'(reqN), 64'h1);
    rd(sync_pkg::OFF_IRQ_STATUS, 32'h0000_0009, OK);
    check(64'(irq), 64'h1);
    wr(sync_pkg::OFF_SLV_CTRL, 32'h0000_0000, OK);
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    tReset();
    tMaster();
    tPass();
    tFail();
    tTimeout();
    tally_and_finish();
  end
endmodule

// [bench/sync_asserts.sv]
/*
  Port checker for multichip_counter_sync.
  Bound into every instance of the top; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module sync_asserts
(
  input wire logic clock,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [sync_pkg::COUNT_W-1:0] counterIn,
  input sync_pkg::sync_msg_s mstTxMsg,
  input wire logic slvReqOut,
  input sync_pkg::sync_msg_s slvRespMsg,
  input wire logic loadPulse,
  input wire logic [sync_pkg::COUNT_W-1:0] loadValue,
  input wire logic stalled
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_MST_COUNT: assert property (mstTxMsg.valid |->
    mstTxMsg.ok && mstTxMsg.count == $past(counterIn))
    else $error("master message count wrong");
  AST_LOAD_CAUSE: assert property (loadPulse |->
    $past(slvRespMsg.valid && slvRespMsg.ok))
    else $error("load without passing answer");
  AST_LOAD_VALUE: assert property (loadPulse |->
    loadValue == $past(slvRespMsg.count))
    else $error("loaded count wrong");
  AST_LOAD_HOLD: assert property (!loadPulse && !$past(rst) |->
    $stable(loadValue))
    else $error("loaded count moved");
  AST_STALL_QUIET: assert property (stalled |->
    !slvReqOut && !loadPulse)
    else $error("activity while stalled");
  AST_REQ_PULSE: assert property (slvReqOut |=> !slvReqOut)
    else $error("requests too close");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_READ_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
  AST_WR_BLOCK: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  cover property (loadPulse);
  cover property ($rose(stalled));
  cover property (mstTxMsg.valid);
endmodule

bind multichip_counter_sync sync_asserts chk (.clock(clock), .rst(rst),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .counterIn(counterIn), .mstTxMsg(mstTxMsg), .slvReqOut(slvReqOut),
  .slvRespMsg(slvRespMsg), .loadPulse(loadPulse),
  .loadValue(loadValue), .stalled(stalled));

// [bench/sync_partner.sv]
/*
  Behavioural master chip answering slave sync requests.
  Expects request pulses synchronous to clock.
*/
`timescale 1ns/1ps
module sync_partner
#(
  parameter int DELAY = 3,
  parameter logic [63:0] BASE = 64'h0000_0000_1234_5678
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic req,
  input wire logic [1:0] mode,
  output sync_pkg::sync_msg_s resp
);
  int waitCnt;
  logic [63:0] sent;
  // Mode 0 passes, 1 fails, 2 never answers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      resp <= '0;
      waitCnt <= 0;
      sent <= 64'h0;
    end
    else if (waitCnt == 1)
    begin
      resp <= '{1'h1, mode == 2'h0, BASE + sent};
      sent <= sent + 64'h1;
      waitCnt <= 0;
    end
    else
    begin
      // Idle payload toggles so a stale value is never trusted
      resp <= '{1'h0, ~resp.ok, ~resp.count};
      if (req && mode != 2'h2)
        waitCnt <= DELAY;
      else if (waitCnt > 1)
        waitCnt <= waitCnt - 1;
    end
  end
endmodule

// [rtl/multichip_counter_sync.sv]
/*
  Top of the multichip counter sync block: AXI4-Lite register slave,
  interrupt status and mask, master and slave sync engines.
  Assumes one 20 MHz clock and link signals synchronous to it.
*/
`timescale 1ns/1ps
module multichip_counter_sync
#(
  parameter int TIMEOUT_CYCLES = sync_pkg::TIMEOUT_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [sync_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sync_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [sync_pkg::COUNT_W-1:0] counterIn,
  input wire logic slaveReqIn,
  output sync_pkg::sync_msg_s mstTxMsg,
  output logic slvReqOut,
  input sync_pkg::sync_msg_s slvRespMsg,
  output logic loadPulse,
  output logic [sync_pkg::COUNT_W-1:0] loadValue,
  output logic stalled,
  output logic irq
);
  sync_pkg::sync_ctrl_s mstCtrl_r;
  sync_pkg::sync_ctrl_s slvCtrl_r;
  logic [sync_pkg::IRQ_W-1:0] irqStatus_r;
  logic [sync_pkg::IRQ_W-1:0] irqMask_r;
  logic [sync_pkg::RETRY_W-1:0] retryLimit_r;
  logic mstImm_r;
  logic slvImm_r;
  sync_pkg::sync_event_s slvEvents;

  logic [sync_pkg::AXI_ADDR_W-1:0] awAddr_r;
  logic awHeld_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic wHeld_r;
  logic wrFire;
  logic wrLow;
  logic [7:0] wrAddr;
  logic [7:0] rdAddr;
  logic wrHit;
  logic rdHit;
  logic [31:0] rdWord;
  logic [sync_pkg::IRQ_W-1:0] eventBits;
  logic [sync_pkg::IRQ_W-1:0] clearBits;

  // Write address and data are accepted in either order
  assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wrFire = awHeld_r & wHeld_r & ~s_axi_bvalid;
  // Every field lives in byte lane 0
  assign wrLow = wrFire & wStrb_r[0];
  assign wrAddr = {awAddr_r[7:2], 2'b00};
  assign rdAddr = {s_axi_araddr[7:2], 2'b00};

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end
    else if (wrFire)
      awHeld_r <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wHeld_r <= 1'b0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end
    else if (wrFire)
      wHeld_r <= 1'b0;
  end

  always_comb
  begin
    case (wrAddr)
      sync_pkg::OFF_MST_CTRL,
      sync_pkg::OFF_SLV_CTRL,
      sync_pkg::OFF_IRQ_STATUS,
      sync_pkg::OFF_IRQ_MASK,
      sync_pkg::OFF_SYNC_STATE,
      sync_pkg::OFF_RETRY_LIMIT:
        wrHit = 1'b1;
      default:
        wrHit = 1'b0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sync_pkg::RESP_OKAY;
    end
    else if (wrFire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHit ? sync_pkg::RESP_OKAY : sync_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mstCtrl_r.enable <= 1'b0;
      mstCtrl_r.turnaround <= sync_pkg::TURN_RESET;
    end
    else if (wrLow && wrAddr == sync_pkg::OFF_MST_CTRL)
    begin
      mstCtrl_r.enable <= wData_r[sync_pkg::CTRL_EN_BIT];
      mstCtrl_r.turnaround <=
        wData_r[sync_pkg::CTRL_TURN_LSB +: sync_pkg::TURN_W];
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      slvCtrl_r.enable <= 1'b0;
      slvCtrl_r.turnaround <= sync_pkg::TURN_RESET;
    end
    else if (wrLow && wrAddr == sync_pkg::OFF_SLV_CTRL)
    begin
      slvCtrl_r.enable <= wData_r[sync_pkg::CTRL_EN_BIT];
      slvCtrl_r.turnaround <=
        wData_r[sync_pkg::CTRL_TURN_LSB +: sync_pkg::TURN_W];
    end
  end

  // Immediate bit is a one-cycle trigger; it never stays set
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mstImm_r <= 1'b0;
      slvImm_r <= 1'b0;
    end
    else
    begin
      mstImm_r <= wrLow && wrAddr == sync_pkg::OFF_MST_CTRL
        && wData_r[sync_pkg::CTRL_IMM_BIT]; // [R8]
      slvImm_r <= wrLow && wrAddr == sync_pkg::OFF_SLV_CTRL
        && wData_r[sync_pkg::CTRL_IMM_BIT]; // [R8]
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      retryLimit_r <= sync_pkg::RETRY_RESET;
    else if (wrLow && wrAddr == sync_pkg::OFF_RETRY_LIMIT)
      retryLimit_r <= wData_r[sync_pkg::RETRY_W-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      irqMask_r <= sync_pkg::MASK_RESET;
    else if (wrLow && wrAddr == sync_pkg::OFF_IRQ_MASK)
      irqMask_r <= wData_r[sync_pkg::IRQ_W-1:0];
  end

  assign eventBits = slvEvents;
  assign clearBits = (wrLow && wrAddr == sync_pkg::OFF_IRQ_STATUS) ?
    wData_r[sync_pkg::IRQ_W-1:0] : 4'h0;

  // A new event outweighs a clear landing in the same cycle
  always_ff @(posedge clock)
  begin
    if (rst)
      irqStatus_r <= sync_pkg::IRQ_RESET;
    else
      irqStatus_r <= (irqStatus_r & ~clearBits) | eventBits; // [R7]
  end

  assign irq = |(irqStatus_r & irqMask_r); // [R7]

  always_comb
  begin
    rdHit = 1'b1;
    rdWord = 32'h0000_0000;
    case (rdAddr)
      sync_pkg::OFF_MST_CTRL:
      begin
        rdWord[sync_pkg::CTRL_EN_BIT] = mstCtrl_r.enable;
        rdWord[sync_pkg::CTRL_TURN_LSB +: sync_pkg::TURN_W] =
          mstCtrl_r.turnaround;
      end
      sync_pkg::OFF_SLV_CTRL:
      begin
        rdWord[sync_pkg::CTRL_EN_BIT] = slvCtrl_r.enable;
        rdWord[sync_pkg::CTRL_TURN_LSB +: sync_pkg::TURN_W] =
          slvCtrl_r.turnaround;
      end
      sync_pkg::OFF_IRQ_STATUS:
        rdWord[sync_pkg::IRQ_W-1:0] = irqStatus_r;
      sync_pkg::OFF_IRQ_MASK:
        rdWord[sync_pkg::IRQ_W-1:0] = irqMask_r;
      sync_pkg::OFF_SYNC_STATE:
        rdWord[0] = stalled;
      sync_pkg::OFF_RETRY_LIMIT:
        rdWord[sync_pkg::RETRY_W-1:0] = retryLimit_r;
      default:
        rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sync_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdWord;
      s_axi_rresp <= rdHit ? sync_pkg::RESP_OKAY : sync_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  sync_master_engine u_master
  (
    .clock(clock),
    .rst(rst),
    .ctrl(mstCtrl_r),
    .immPulse(mstImm_r),
    .slaveReq(slaveReqIn),
    .counterIn(counterIn),
    .txMsg(mstTxMsg)
  );

  sync_slave_engine
  #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
  )
  u_slave
  (
    .clock(clock),
    .rst(rst),
    .ctrl(slvCtrl_r),
    .immPulse(slvImm_r),
    .retryLimit(retryLimit_r),
    .respMsg(slvRespMsg),
    .syncReq(slvReqOut),
    .loadPulse(loadPulse),
    .loadValue(loadValue),
    .events(slvEvents),
    .stalled(stalled)
  );
endmodule

// [rtl/sync_master_engine.sv]
/*
  Master-chip sync engine: issues counter sync transactions on request.
  Assumes requests from slave chips are synchronous one-cycle pulses.
*/
`timescale 1ns/1ps
module sync_master_engine
(
  input wire logic clock,
  input wire logic rst,
  input sync_pkg::sync_ctrl_s ctrl,
  input wire logic immPulse,
  input wire logic slaveReq,
  input wire logic [sync_pkg::COUNT_W-1:0] counterIn,
  output sync_pkg::sync_msg_s txMsg
);
  logic [sync_pkg::TURN_W-1:0] gap_r;
  logic pend_r;
  logic want;
  logic fire;
  logic [sync_pkg::TURN_W-1:0] turnEff;

  assign want = ctrl.enable & (immPulse | slaveReq); // [R8]
  assign fire = ctrl.enable & pend_r & (gap_r == 5'h00); // [R1]
  // Zero turnaround still means one clock between starts
  assign turnEff = (ctrl.turnaround == 5'h00) ? 5'h01 : ctrl.turnaround;

  always_ff @(posedge clock)
  begin
    if (rst)
      gap_r <= 5'h00;
    else if (fire)
      gap_r <= turnEff - 5'h01; // [R1]
    else if (gap_r != 5'h00)
      gap_r <= gap_r - 5'h01;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      pend_r <= 1'b0;
    else if (!ctrl.enable)
      pend_r <= 1'b0; // [R8]
    else if (want)
      pend_r <= 1'b1;
    else if (fire)
      pend_r <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      txMsg <= '0;
    else
    begin
      txMsg.valid <= fire;
      txMsg.ok <= fire;
      if (fire)
        txMsg.count <= counterIn;
    end
  end
endmodule

// [rtl/sync_pkg.sv]
/*
  Shared constants, types and register map of the multichip counter
  synchronisation block. Assumes a single 20 MHz clock and AXI4-Lite.
*/
// Summary of operation
// [R1] The master engine spaces the starts of its transactions by the turnaround clocks.
// [R2] The slave engine spaces the starts of retried requests by its turnaround clocks.
// [R3] The slave flags a timeout when the master does not answer a request in time.
// [R4] The slave flags failure when a software-requested immediate sync fails.
// [R5] The slave flags success when a software-requested immediate sync passes.
// [R6] The slave flags exhaustion when sync still fails after the set retries.
// [R7] The slave retries up to the retry limit, then interrupts and stalls.
// [R8] Each engine runs only while enabled; the immediate bit starts one at once.
package sync_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam int COUNT_W = 64;
  localparam int TURN_W = 5;
  localparam int RETRY_W = 5;
  localparam int IRQ_W = 4;

  localparam logic [7:0] OFF_MST_CTRL = 8'h00;
  localparam logic [7:0] OFF_SLV_CTRL = 8'h04;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_SYNC_STATE = 8'h10;
  localparam logic [7:0] OFF_RETRY_LIMIT = 8'h28;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_IMM_BIT = 1;
  localparam int CTRL_TURN_LSB = 2;
  localparam int IRQ_EXHAUST_BIT = 0;
  localparam int IRQ_PASS_BIT = 1;
  localparam int IRQ_FAIL_BIT = 2;
  localparam int IRQ_TIMEOUT_BIT = 3;

  localparam logic [TURN_W-1:0] TURN_RESET = 5'h00;
  localparam logic [RETRY_W-1:0] RETRY_RESET = 5'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam int CLK_PERIOD_NS = 50;
  localparam int TIMEOUT_NS = 10000;
  localparam int TIMEOUT_CYCLES =
    (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [TURN_W-1:0] turnaround;
    logic enable;
  } sync_ctrl_s;

  // Layout matches the interrupt status register
  typedef struct packed {
    logic timeout;
    logic failed;
    logic passed;
    logic exhausted;
  } sync_event_s;

  // One sync message: master broadcast or answer to a slave
  typedef struct packed {
    logic valid;
    logic ok;
    logic [COUNT_W-1:0] count;
  } sync_msg_s;

  typedef enum logic [1:0] {
    SL_IDLE = 2'b00,
    SL_WAIT = 2'b01,
    SL_GAP = 2'b10,
    SL_STALL = 2'b11
  } slave_state_e;
endpackage

// [rtl/sync_slave_engine.sv]
/*
  Slave-chip sync engine: requests the master count, retries, stalls.
  Assumes the answer arrives as a one-cycle message from the master chip.
*/
`timescale 1ns/1ps
module sync_slave_engine
#(
  parameter int TIMEOUT_CYCLES = sync_pkg::TIMEOUT_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input sync_pkg::sync_ctrl_s ctrl,
  input wire logic immPulse,
  input wire logic [sync_pkg::RETRY_W-1:0] retryLimit,
  input sync_pkg::sync_msg_s respMsg,
  output logic syncReq,
  output logic loadPulse,
  output logic [sync_pkg::COUNT_W-1:0] loadValue,
  output sync_pkg::sync_event_s events,
  output logic stalled
);
  sync_pkg::slave_state_e state_r;
  logic [sync_pkg::TURN_W-1:0] gap_r;
  logic [sync_pkg::RETRY_W-1:0] tries_r;
  logic [15:0] timer_r;
  logic immSeq_r;
  logic enPrev_r;
  logic beginSeq;
  logic timedOut;
  logic failNow;
  logic passNow;
  logic retryNow;
  logic [sync_pkg::TURN_W-1:0] turnEff;

  assign beginSeq = ctrl.enable & (immPulse | ~enPrev_r)
    & (state_r == sync_pkg::SL_IDLE); // [R8]
  assign timedOut = (state_r == sync_pkg::SL_WAIT) & ~respMsg.valid
    & (timer_r == 16'(TIMEOUT_CYCLES - 1)); // [R3]
  assign passNow = (state_r == sync_pkg::SL_WAIT) & respMsg.valid
    & respMsg.ok;
  assign failNow = timedOut | ((state_r == sync_pkg::SL_WAIT)
    & respMsg.valid & ~respMsg.ok);
  assign retryNow = (state_r == sync_pkg::SL_GAP) & (gap_r == 5'h00);
  assign turnEff = (ctrl.turnaround == 5'h00) ? 5'h01 : ctrl.turnaround;
  assign stalled = (state_r == sync_pkg::SL_STALL);

  always_ff @(posedge clock)
  begin
    if (rst)
      enPrev_r <= 1'b0;
    else
      enPrev_r <= ctrl.enable;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      state_r <= sync_pkg::SL_IDLE;
    else if (!ctrl.enable)
      state_r <= sync_pkg::SL_IDLE; // [R8]
    else
    begin
      case (state_r)
        sync_pkg::SL_IDLE:
          if (beginSeq)
            state_r <= sync_pkg::SL_WAIT;
        sync_pkg::SL_WAIT:
          if (passNow)
            state_r <= sync_pkg::SL_IDLE;
          else if (failNow && tries_r >= retryLimit)
            state_r <= sync_pkg::SL_STALL; // [R7]
          else if (failNow)
            state_r <= sync_pkg::SL_GAP;
        sync_pkg::SL_GAP:
          if (retryNow)
            state_r <= sync_pkg::SL_WAIT;
        sync_pkg::SL_STALL:
          state_r <= sync_pkg::SL_STALL;
        default:
          state_r <= sync_pkg::SL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst || beginSeq)
      tries_r <= 5'h00;
    else if (failNow && tries_r < retryLimit)
      tries_r <= tries_r + 5'h01; // [R7]
  end

  // Gap counts from the start of the previous request
  always_ff @(posedge clock)
  begin
    if (rst)
      gap_r <= 5'h00;
    else if (beginSeq || retryNow)
      gap_r <= turnEff - 5'h01; // [R2]
    else if (gap_r != 5'h00)
      gap_r <= gap_r - 5'h01;
  end

  always_ff @(posedge clock)
  begin
    if (rst || beginSeq || retryNow)
      timer_r <= 16'h0000;
    else if (state_r == sync_pkg::SL_WAIT)
      timer_r <= timer_r + 16'h0001;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      immSeq_r <= 1'b0;
    else if (beginSeq)
      immSeq_r <= immPulse;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      syncReq <= 1'b0;
      loadPulse <= 1'b0;
      loadValue <= '0;
      events <= '0;
    end
    else
    begin
      syncReq <= beginSeq | retryNow;
      loadPulse <= passNow;
      if (passNow)
        loadValue <= respMsg.count;
      events.timeout <= timedOut; // [R3]
      events.passed <= passNow & immSeq_r; // [R5]
      events.failed <= failNow & immSeq_r
        & (tries_r >= retryLimit); // [R4]
      events.exhausted <= failNow & (tries_r >= retryLimit); // [R6]
    end
  end
endmodule
